/* verilog/ecs_pkg.sv */
// Shared constants, enumerations and carriers of the instruction sequencer.
// Assumes an external decoder classifies each fetched word and an external
// datapath supplies operands, load/store requests and branch targets.
package ecs_pkg;

	// ------------------------------------------------------------------
	// Widths and vectors
	// ------------------------------------------------------------------
	localparam int          XLEN         = 32;
	localparam int          ADDR_W       = 32;
	localparam int          CNT_W        = 5;
	localparam logic [31:0] RESET_VECTOR = 32'h0000_0000;
	localparam logic [31:0] EXC_VECTOR   = 32'h0000_0020;
	localparam logic [31:0] INSN_STEP    = 32'h0000_0004;

	// ------------------------------------------------------------------
	// Cycle figures
	// ------------------------------------------------------------------
	localparam int BASE_CYCLES      = 6;
	localparam int HALF_LOAD_CYCLES = 9;
	localparam int BYTE_LOAD_CYCLES = 10;
	localparam int SHIFT_MIN_CYCLES = 7;
	localparam int SHIFT_MAX_CYCLES = 38;
	// Counter preload: extract state lasts preload + 1 cycles
	localparam logic [CNT_W-1:0] HALF_EXTRACT_LOAD =
		CNT_W'(HALF_LOAD_CYCLES - BASE_CYCLES - 1);
	localparam logic [CNT_W-1:0] BYTE_EXTRACT_LOAD =
		CNT_W'(BYTE_LOAD_CYCLES - BASE_CYCLES - 1);

	// ------------------------------------------------------------------
	// Enumerations
	// ------------------------------------------------------------------
	typedef enum logic [3:0] {
		CL_ALU          = 4'h0,
		CL_BRANCH       = 4'h1,
		CL_JUMP         = 4'h2,
		CL_CTRL         = 4'h3,
		CL_TRAP         = 4'h4,
		CL_LOAD         = 4'h5,
		CL_STORE        = 4'h6,
		CL_SHIFT        = 4'h7,
		CL_CUSTOM_COMB  = 4'h8,
		CL_CUSTOM_MULTI = 4'h9,
		CL_UNIMPL       = 4'ha,
		CL_OTHER        = 4'hb
	} ecs_class_t;

	typedef enum logic [1:0] {
		SZ_WORD = 2'h0,
		SZ_HALF = 2'h1,
		SZ_BYTE = 2'h2
	} ecs_size_t;

	typedef enum logic [2:0] {
		SH_SLL = 3'h0,
		SH_SRL = 3'h1,
		SH_SRA = 3'h2,
		SH_ROL = 3'h3,
		SH_ROR = 3'h4
	} ecs_shift_t;

	typedef enum logic [1:0] {
		EXC_NONE   = 2'h0,
		EXC_IRQ    = 2'h1,
		EXC_TRAP   = 2'h2,
		EXC_UNIMPL = 2'h3
	} ecs_cause_t;

	typedef enum logic [3:0] {
		ST_BOOT       = 4'h0,
		ST_FETCH      = 4'h1,
		ST_DECODE     = 4'h2,
		ST_OPERAND    = 4'h3,
		ST_EXECUTE    = 4'h4,
		ST_BUS        = 4'h5,
		ST_EXTRACT    = 4'h6,
		ST_SHIFT      = 4'h7,
		ST_WRITEBACK  = 4'h8,
		ST_RETIRE     = 4'h9,
		ST_RESET_HOLD = 4'ha,
		ST_HALT       = 4'hb
	} ecs_state_t;

	// ------------------------------------------------------------------
	// Carriers
	// ------------------------------------------------------------------
	typedef struct packed {
		ecs_class_t       opClass;
		ecs_size_t        size;
		logic             signedLoad;
		ecs_shift_t       shiftKind;
		logic [CNT_W-1:0] shiftAmount;
		logic             writesReg;
	} ecs_op_t;

	typedef struct packed {
		logic             redirect;
		logic [ADDR_W-1:0] target;
	} ecs_flow_t;

	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic [XLEN-1:0]   wdata;
		logic [3:0]        be;
	} ecs_dreq_t;

endpackage : ecs_pkg

/* verilog/ecs_down_counter.sv */
// Loadable down counter that times the multi-cycle states.
// Assumes load and decrement are never asserted together.
`timescale 1ns/1ps
module ecs_down_counter
	import ecs_pkg::*;
#(
	parameter int W = CNT_W
) (
	input  wire logic         clk,
	input  wire logic         reset_n,
	input  wire logic         load,
	input  wire logic [W-1:0] loadValue,
	input  wire logic         decrement,
	output logic      [W-1:0] count,
	output logic              zero
);

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			count <= '0;
		end else if (load) begin
			count <= loadValue;
		end else if (decrement && count != '0) begin
			count <= count - W'(1);
		end
	end

	assign zero = (count == '0);

endmodule : ecs_down_counter

/* verilog/ecs_bus_port.sv */
// Master port: holds a read or write strobe until wait request drops.
// Assumes the slave samples address and data while the strobe is high.
`timescale 1ns/1ps
module ecs_bus_port
	import ecs_pkg::*;
(
	input  wire logic              clk,
	input  wire logic              reset_n,
	input  wire logic              start,
	input  wire logic              startWrite,
	input  wire logic [ADDR_W-1:0] startAddr,
	input  wire logic [XLEN-1:0]   startData,
	input  wire logic [3:0]        startBe,
	input  wire logic              waitRequest,
	output logic                   read,
	output logic                   write,
	output logic      [ADDR_W-1:0] address,
	output logic      [XLEN-1:0]   writeData,
	output logic      [3:0]        byteEnable,
	output logic                   done
);

	assign done = (read | write) & ~waitRequest;

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			read       <= 1'b0;
			write      <= 1'b0;
			address    <= '0;
			writeData  <= '0;
			byteEnable <= 4'h0;
		end else if (start) begin
			read       <= ~startWrite;
			write      <= startWrite;
			// Top address bit never reaches the bus; no uncached alias
			address    <= {1'b0, startAddr[ADDR_W-2:0]};
			writeData  <= startData;
			byteEnable <= startBe;
		end else if (done) begin
			read  <= 1'b0;
			write <= 1'b0;
		end
	end

endmodule : ecs_bus_port

/* verilog/ecs_sequencer.sv */
// Instruction sequencer of the economy core: fetch, execute, retire, one at a time.
// Assumes a decoder classifies iReadData combinationally and a datapath
// presents flow, dataReq and shiftOperand while the stage output is EXECUTE.
`timescale 1ns/1ps
module ecs_sequencer
	import ecs_pkg::*;
(
	input  wire logic              clk,
	input  wire logic              reset_n,
	output logic                   iRead,
	output logic      [ADDR_W-1:0] iAddress,
	input  wire logic [XLEN-1:0]   iReadData,
	input  wire logic              iWaitRequest,
	output logic                   dRead,
	output logic                   dWrite,
	output logic      [ADDR_W-1:0] dAddress,
	output logic      [XLEN-1:0]   dWriteData,
	output logic      [3:0]        dByteEnable,
	input  wire logic [XLEN-1:0]   dReadData,
	input  wire logic              dWaitRequest,
	input  wire ecs_op_t           decodedOp,
	input  wire ecs_flow_t         flow,
	input  wire ecs_dreq_t         dataReq,
	input  wire logic [XLEN-1:0]   shiftOperand,
	input  wire logic              customDone,
	input  wire logic              irq,
	input  wire logic              resetRequest,
	input  wire logic              debugHaltReq,
	output logic      [XLEN-1:0]   insnWord,
	output logic      [ADDR_W-1:0] pc,
	output ecs_state_t             stage,
	output logic                   regWrite,
	output logic                   customStart,
	output logic                   retire,
	output logic                   exceptionTaken,
	output ecs_cause_t             exceptionCause,
	output logic                   resetTaken,
	output logic                   debugHalted,
	output logic      [XLEN-1:0]   shiftResult,
	output logic      [XLEN-1:0]   loadResult
);

	// ------------------------------------------------------------------
	// Declarations
	// ------------------------------------------------------------------
	ecs_state_t        state;
	ecs_state_t        next_state;
	ecs_op_t           op;
	ecs_cause_t        cause;
	logic [ADDR_W-1:0] nextPc;
	logic [ADDR_W-1:0] fetchTarget;
	logic [1:0]        laneSel;
	logic              iStart;
	logic              iDone;
	logic              dStart;
	logic              dDone;
	logic              cntLoad;
	logic [CNT_W-1:0]  cntLoadValue;
	logic              cntDec;
	logic              cntZero;
	logic              isLoad;

	assign stage  = state;
	assign isLoad = (op.opClass == CL_LOAD);

	// ------------------------------------------------------------------
	// Sequencing
	// ------------------------------------------------------------------
	always_comb begin
		next_state = state;
		case (state)
			ST_BOOT: begin
				next_state = ST_FETCH;
			end
			ST_FETCH: begin
				if (iDone) begin
					next_state = ST_DECODE;
				end
			end
			ST_DECODE: begin
				next_state = ST_OPERAND;
			end
			ST_OPERAND: begin
				next_state = ST_EXECUTE;
			end
			ST_EXECUTE: begin
				if (cause != EXC_NONE) begin
					next_state = ST_WRITEBACK;
				end else begin
					case (op.opClass)
						CL_LOAD, CL_STORE: next_state = ST_BUS;
						CL_SHIFT:          next_state = ST_SHIFT;
						CL_CUSTOM_MULTI: begin
							if (customDone) begin
								next_state = ST_WRITEBACK;
							end
						end
						// Arithmetic, flow, control and unknown words alike
						default:           next_state = ST_WRITEBACK;
					endcase
				end
			end
			ST_BUS: begin
				if (dDone) begin
					if (isLoad && op.size != SZ_WORD) begin
						next_state = ST_EXTRACT;
					end else begin
						next_state = ST_WRITEBACK;
					end
				end
			end
			ST_EXTRACT, ST_SHIFT: begin
				if (cntZero) begin
					next_state = ST_WRITEBACK;
				end
			end
			ST_WRITEBACK: begin
				next_state = ST_RETIRE;
			end
			ST_RETIRE: begin
				// Requests are honoured only between instructions
				if (resetRequest) begin
					next_state = ST_RESET_HOLD;
				end else if (debugHaltReq) begin
					next_state = ST_HALT;
				end else begin
					next_state = ST_FETCH;
				end
			end
			ST_RESET_HOLD: begin
				if (!resetRequest) begin
					next_state = ST_FETCH;
				end
			end
			ST_HALT: begin
				if (resetRequest) begin
					next_state = ST_RESET_HOLD;
				end else if (!debugHaltReq) begin
					next_state = ST_FETCH;
				end
			end
			default: begin
				next_state = ST_BOOT;
			end
		endcase
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			state <= ST_BOOT;
		end else begin
			state <= next_state;
		end
	end

	// ------------------------------------------------------------------
	// Instruction fetch
	// ------------------------------------------------------------------
	// Target is known once the instruction has executed; fetch reads nextPc in RETIRE or HALT
	always_comb begin
		case (state)
			ST_RETIRE: fetchTarget = nextPc;
			ST_HALT:   fetchTarget = nextPc;
			default:   fetchTarget = RESET_VECTOR;
		endcase
	end

	assign iStart = (next_state == ST_FETCH) && (state != ST_FETCH);

	ecs_bus_port u_instr_port (
		.clk         (clk),
		.reset_n     (reset_n),
		.start       (iStart),
		.startWrite  (1'b0),
		.startAddr   (fetchTarget),
		.startData   ('0),
		.startBe     (4'hf),
		.waitRequest (iWaitRequest),
		.read        (iRead),
		.write       (),
		.address     (iAddress),
		.writeData   (),
		.byteEnable  (),
		.done        (iDone)
	);

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			pc       <= RESET_VECTOR;
			insnWord <= '0;
			op       <= '0;
			cause    <= EXC_NONE;
		end else begin
			if (iStart) begin
				pc <= fetchTarget;
			end
			if (state == ST_FETCH && iDone) begin
				insnWord <= iReadData;
				op       <= decodedOp;
				// Interrupt outranks whatever the fetched word would do
				if (irq) begin
					cause <= EXC_IRQ;
				end else if (decodedOp.opClass == CL_TRAP) begin
					cause <= EXC_TRAP;
				end else if (decodedOp.opClass == CL_UNIMPL) begin
					cause <= EXC_UNIMPL;
				end else begin
					cause <= EXC_NONE;
				end
			end
		end
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			nextPc <= RESET_VECTOR;
		end else if (state == ST_EXECUTE) begin
			if (cause != EXC_NONE) begin
				nextPc <= EXC_VECTOR;
			end else if (flow.redirect) begin
				nextPc <= flow.target;
			end else begin
				nextPc <= pc + INSN_STEP;
			end
		end
	end

	// ------------------------------------------------------------------
	// Data access
	// ------------------------------------------------------------------
	assign dStart = (state == ST_EXECUTE) && (next_state == ST_BUS);

	ecs_bus_port u_data_port (
		.clk         (clk),
		.reset_n     (reset_n),
		.start       (dStart),
		.startWrite  (op.opClass == CL_STORE),
		.startAddr   (dataReq.addr),
		.startData   (dataReq.wdata),
		.startBe     (dataReq.be),
		.waitRequest (dWaitRequest),
		.read        (dRead),
		.write       (dWrite),
		.address     (dAddress),
		.writeData   (dWriteData),
		.byteEnable  (dByteEnable),
		.done        (dDone)
	);

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			laneSel <= 2'h0;
		end else if (dStart) begin
			laneSel <= dataReq.addr[1:0];
		end
	end

	// ------------------------------------------------------------------
	// Multi-cycle timing: shift bits and sub-word extraction
	// ------------------------------------------------------------------
	assign cntLoad      = (state == ST_EXECUTE && next_state == ST_SHIFT) ||
	                      (state == ST_BUS && next_state == ST_EXTRACT);
	assign cntLoadValue = (state == ST_EXECUTE) ? op.shiftAmount :
	                      (op.size == SZ_HALF) ? HALF_EXTRACT_LOAD : BYTE_EXTRACT_LOAD;
	assign cntDec       = (state == ST_SHIFT) || (state == ST_EXTRACT);

	ecs_down_counter #(
		.W (CNT_W)
	) u_step_counter (
		.clk       (clk),
		.reset_n   (reset_n),
		.load      (cntLoad),
		.loadValue (cntLoadValue),
		.decrement (cntDec),
		.count     (),
		.zero      (cntZero)
	);

	// Serial shifter trades speed for area: one position per cycle
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			shiftResult <= '0;
		end else if (state == ST_EXECUTE && op.opClass == CL_SHIFT) begin
			shiftResult <= shiftOperand;
		end else if (state == ST_SHIFT && !cntZero) begin
			case (op.shiftKind)
				SH_SLL:  shiftResult <= {shiftResult[XLEN-2:0], 1'b0};
				SH_SRL:  shiftResult <= {1'b0, shiftResult[XLEN-1:1]};
				SH_SRA:  shiftResult <= {shiftResult[XLEN-1], shiftResult[XLEN-1:1]};
				SH_ROL:  shiftResult <= {shiftResult[XLEN-2:0], shiftResult[XLEN-1]};
				SH_ROR:  shiftResult <= {shiftResult[0], shiftResult[XLEN-1:1]};
				default: shiftResult <= shiftResult;
			endcase
		end
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			loadResult <= '0;
		end else if (state == ST_BUS && dDone && isLoad) begin
			loadResult <= dReadData;
		end else if (state == ST_EXTRACT && cntZero) begin
			if (op.size == SZ_HALF) begin
				loadResult <= laneSel[1] ?
					{{16{op.signedLoad & loadResult[31]}}, loadResult[31:16]} :
					{{16{op.signedLoad & loadResult[15]}}, loadResult[15:0]};
			end else begin
				case (laneSel)
					2'h0:    loadResult <= {{24{op.signedLoad & loadResult[7]}},
					                        loadResult[7:0]};
					2'h1:    loadResult <= {{24{op.signedLoad & loadResult[15]}},
					                        loadResult[15:8]};
					2'h2:    loadResult <= {{24{op.signedLoad & loadResult[23]}},
					                        loadResult[23:16]};
					default: loadResult <= {{24{op.signedLoad & loadResult[31]}},
					                        loadResult[31:24]};
				endcase
			end
		end
	end

	// ------------------------------------------------------------------
	// Strobes and status
	// ------------------------------------------------------------------
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			regWrite       <= 1'b0;
			customStart    <= 1'b0;
			retire         <= 1'b0;
			exceptionTaken <= 1'b0;
			exceptionCause <= EXC_NONE;
			resetTaken     <= 1'b0;
			debugHalted    <= 1'b0;
		end else begin
			regWrite       <= (next_state == ST_WRITEBACK) && (state != ST_WRITEBACK) &&
			                  op.writesReg && (cause == EXC_NONE);
			customStart    <= (state == ST_OPERAND) && (op.opClass == CL_CUSTOM_MULTI) &&
			                  (cause == EXC_NONE);
			retire         <= (next_state == ST_RETIRE);
			exceptionTaken <= (next_state == ST_RETIRE) && (cause != EXC_NONE);
			if (next_state == ST_RETIRE) begin
				exceptionCause <= cause;
			end
			resetTaken     <= (next_state == ST_RESET_HOLD);
			debugHalted    <= (next_state == ST_HALT);
		end
	end

endmodule : ecs_sequencer

/* verif/ecs_mem_model.sv */
// Memory model for the instruction and data master ports.
// Assumes strobes stay up until wait request drops; waits are set per transfer.
`timescale 1ns/1ps
module ecs_mem_model
	import ecs_pkg::*;
(
	input  wire logic        clk,
	input  wire logic        iRead,
	input  wire logic [31:0] iAddress,
	output logic      [31:0] iReadData,
	output logic             iWaitRequest,
	input  wire logic        dRead,
	input  wire logic        dWrite,
	input  wire logic [31:0] dAddress,
	input  wire logic [31:0] dWriteData,
	input  wire logic [3:0]  dByteEnable,
	output logic      [31:0] dReadData,
	output logic             dWaitRequest,
	input  wire logic [31:0] iWaits,
	input  wire logic [31:0] dWaits
);
	// ------------------------------------------------------------------
	// Slave behaviour
	// ------------------------------------------------------------------
	logic [31:0] mem [16];
	logic [31:0] lastI;
	logic [31:0] lastD;
	int          iCnt;
	int          dCnt;
	assign iWaitRequest = iRead && (iCnt < iWaits);
	assign dWaitRequest = (dRead || dWrite) && (dCnt < dWaits);
	// Idle data lines flip every cycle so a stale word never looks valid
	assign iReadData = (iRead && !iWaitRequest) ? {iAddress[15:0], 16'h5a3c} : ~lastI;
	assign dReadData = (dRead && !dWaitRequest) ? mem[dAddress[5:2]] : ~lastD;
	always_ff @(posedge clk) begin
		iCnt <= iWaitRequest ? iCnt + 1 : 0;
		dCnt <= dWaitRequest ? dCnt + 1 : 0;
		lastI <= iReadData;
		lastD <= dReadData;
		for (int b = 0; b < 4; b++) begin
			if (dWrite && !dWaitRequest && dByteEnable[b]) begin
				mem[dAddress[5:2]][8*b +: 8] <= dWriteData[8*b +: 8];
			end
		end
	end
endmodule : ecs_mem_model

/* verif/ecs_seq_properties.sv */
// Checker for the sequencer: fetch spacing, class timing, exceptions, bus holds.
// Assumes it is bound to the top module and sees only its ports.
`timescale 1ns/1ps
module ecs_seq_properties
	import ecs_pkg::*;
(
	input wire logic        clk,
	input wire logic        reset_n,
	input wire logic        iRead,
	input wire logic [31:0] iAddress,
	input wire logic        iWaitRequest,
	input wire logic        dRead,
	input wire logic        dWrite,
	input wire logic [31:0] dAddress,
	input wire logic        dWaitRequest,
	input wire ecs_op_t     decodedOp,
	input wire logic        irq,
	input wire logic        resetRequest,
	input wire logic        debugHaltReq,
	input wire logic        retire,
	input wire logic        exceptionTaken,
	input wire logic        regWrite,
	input wire logic        resetTaken,
	input wire logic        debugHalted
);
	// ------------------------------------------------------------------
	// Properties
	// ------------------------------------------------------------------
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!reset_n);
	sequence s_take;
		iRead && !iWaitRequest;
	endsequence
	sequence s_go_on;
		retire && !resetRequest && !debugHaltReq;
	endsequence
	property p_fetch_hold;
		iRead && iWaitRequest |=> iRead && $stable(iAddress);
	endproperty
	a_fetch_hold: assert property (p_fetch_hold) else $error("fetch dropped");
	property p_gap;
		s_take |=> (!iRead) [*5];
	endproperty
	a_gap: assert property (p_gap) else $error("fetch too soon");
	property p_six;
		s_take ##0 (!irq && decodedOp.opClass inside {CL_ALU, CL_BRANCH, CL_JUMP, CL_CTRL})
			|-> ##5 (retire && !exceptionTaken);
	endproperty
	a_six: assert property (p_six) else $error("plain op not six");
	property p_exc;
		s_take ##0 (irq || decodedOp.opClass inside {CL_TRAP, CL_UNIMPL})
			|-> ##5 (retire && exceptionTaken);
	endproperty
	a_exc: assert property (p_exc) else $error("exception entry wrong");
	property p_next;
		s_go_on |=> iRead && (!$past(exceptionTaken) || iAddress == EXC_VECTOR);
	endproperty
	a_next: assert property (p_next) else $error("no refetch");
	property p_top_bit;
		!((iRead && iAddress[31]) || ((dRead || dWrite) && dAddress[31]));
	endproperty
	a_top_bit: assert property (p_top_bit) else $error("top bit driven");
	property p_dhold;
		(dRead || dWrite) && dWaitRequest |=> $stable({dRead, dWrite, dAddress});
	endproperty
	a_dhold: assert property (p_dhold) else $error("data access moved");
	property p_excl;
		(dRead || dWrite) |-> !iRead;
	endproperty
	a_excl: assert property (p_excl) else $error("overlap");
	property p_rst_ack;
		retire && resetRequest |=> resetTaken;
	endproperty
	a_rst_ack: assert property (p_rst_ack) else $error("reset not taken");
	property p_halt;
		retire && debugHaltReq && !resetRequest |=> debugHalted;
	endproperty
	a_halt: assert property (p_halt) else $error("no halt");
	property p_wb;
		regWrite |=> retire && !exceptionTaken;
	endproperty
	a_wb: assert property (p_wb) else $error("writeback not retired");
endmodule : ecs_seq_properties

bind ecs_sequencer ecs_seq_properties u_ecs_seq_properties (.clk(clk), .reset_n(reset_n),
	.iRead(iRead), .iAddress(iAddress), .iWaitRequest(iWaitRequest), .dRead(dRead),
	.dWrite(dWrite), .dAddress(dAddress), .dWaitRequest(dWaitRequest),
	.decodedOp(decodedOp), .irq(irq), .resetRequest(resetRequest),
	.debugHaltReq(debugHaltReq), .retire(retire), .exceptionTaken(exceptionTaken),
	.regWrite(regWrite), .resetTaken(resetTaken), .debugHalted(debugHalted));

/* verif/test_economy_core_instruction_sequencer.sv */
// Bench for the sequencer: class timing, exceptions, loads, stores, hold states.
// Assumes the memory model serves both ports; bench plays decoder and datapath.
`timescale 1ns/1ps
module test_economy_core_instruction_sequencer
	import ecs_pkg::*;
;
	logic        clk, reset_n, iRead, iWaitRequest, dRead, dWrite, dWaitRequest, irq;
	logic        customDone, resetRequest, debugHaltReq, customStart, retire, regWrite;
	logic        exceptionTaken, resetTaken, debugHalted;
	logic [31:0] iAddress, iReadData, dAddress, dWriteData, dReadData, shiftOperand;
	logic [31:0] insnWord, shiftResult, loadResult;
	logic [3:0]  dByteEnable;
	ecs_op_t     decodedOp;
	ecs_flow_t   flow;
	ecs_dreq_t   dataReq;
	ecs_cause_t  exceptionCause;
	int          iWaits, dWaits, custDelay, custCnt, nW, nX, nD, nH, tick;
	int          n_mismatch, num_checks;

	ecs_sequencer u_ecs_sequencer (.clk(clk), .reset_n(reset_n), .iRead(iRead),
		.iAddress(iAddress), .iReadData(iReadData), .iWaitRequest(iWaitRequest),
		.dRead(dRead), .dWrite(dWrite), .dAddress(dAddress), .dWriteData(dWriteData),
		.dByteEnable(dByteEnable), .dReadData(dReadData), .dWaitRequest(dWaitRequest),
		.decodedOp(decodedOp), .flow(flow), .dataReq(dataReq), .shiftOperand(shiftOperand),
		.customDone(customDone), .irq(irq), .resetRequest(resetRequest),
		.debugHaltReq(debugHaltReq), .insnWord(insnWord), .pc(), .stage(),
		.regWrite(regWrite), .customStart(customStart), .retire(retire),
		.exceptionTaken(exceptionTaken), .exceptionCause(exceptionCause),
		.resetTaken(resetTaken), .debugHalted(debugHalted), .shiftResult(shiftResult),
		.loadResult(loadResult));
	ecs_mem_model u_ecs_mem_model (.clk(clk), .iRead(iRead), .iAddress(iAddress),
		.iReadData(iReadData), .iWaitRequest(iWaitRequest), .dRead(dRead), .dWrite(dWrite),
		.dAddress(dAddress), .dWriteData(dWriteData), .dByteEnable(dByteEnable),
		.dReadData(dReadData), .dWaitRequest(dWaitRequest), .iWaits(iWaits), .dWaits(dWaits));

	// ------------------------------------------------------------------
	// Clock, custom unit stand-in, timeout
	// ------------------------------------------------------------------
	always #12.5 clk = ~clk;
	always @(negedge clk) begin
		custCnt = customStart ? 0 : custCnt + 1;
		customDone = custCnt >= custDelay;
	end
	always @(posedge clk) begin
		tick++;
		if (tick == 5000) begin
			n_mismatch++;
			complete_run();
		end
	end

	// ------------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------------
	function automatic ecs_op_t mkOp(ecs_class_t c, ecs_size_t s, logic [4:0] a, logic w);
		return '{c, s, 1'b1, SH_SLL, a, w};
	endfunction : mkOp
	task automatic chk(input logic [31:0] got, exp);
		num_checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	// Counts cycles up to the next fetch start; releases hold requests after three cycles
	task automatic run_to_fetch(output int n);
		logic prev;
		prev = iRead;
		n = 0;
		nW = 0;
		nX = 0;
		nD = 0;
		nH = 0;
		do begin
			@(negedge clk);
			n++;
			irq = 1'b0;
			nW += regWrite;
			nX += exceptionTaken;
			nD += dRead || dWrite;
			nH += resetTaken || debugHalted;
			if (nH == 3) begin
				resetRequest = 1'b0;
				debugHaltReq = 1'b0;
			end
			if (iRead && !prev) break;
			prev = iRead;
		end while (n < 100);
	endtask : run_to_fetch
	// Entered at the falling edge just after a fetch starts; irq only with zero fetch waits
	task automatic do_op(input ecs_op_t o, input int iw, dw, cyc, input logic irqIn);
		logic [31:0] a;
		logic        x;
		int          n;
		a = iAddress;
		x = irqIn || o.opClass inside {CL_TRAP, CL_UNIMPL};
		decodedOp = o;
		iWaits = iw;
		dWaits = dw;
		irq = irqIn;
		run_to_fetch(n);
		chk(n, cyc);
		chk(nX, x);
		chk(exceptionCause, !x ? EXC_NONE : irqIn ? EXC_IRQ : o.opClass == CL_TRAP ? EXC_TRAP
			: EXC_UNIMPL);
		chk(nW, o.writesReg && !x);
		chk(nD, (o.opClass inside {CL_LOAD, CL_STORE}) ? dw + 1 : 0);
		chk(insnWord, {a[15:0], 16'h5a3c});
		chk(iAddress, x ? EXC_VECTOR : flow.redirect ? {1'b0, flow.target[30:0]}
			: a + INSN_STEP);
	endtask : do_op

	// ------------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------------
	task automatic t_basic();
		do_op(mkOp(CL_ALU, SZ_WORD, 5'h00, 1'b1), 0, 0, 6, 1'b0);
		do_op(mkOp(CL_ALU, SZ_WORD, 5'h00, 1'b1), 3, 0, 9, 1'b0);
		do_op(mkOp(CL_ALU, SZ_WORD, 5'h00, 1'b1), 0, 0, 6, 1'b1);
	endtask : t_basic
	task automatic t_flow();
		flow = '{1'b1, 32'h8000_0100};
		do_op(mkOp(CL_BRANCH, SZ_WORD, 5'h00, 1'b0), 0, 0, 6, 1'b0);
		flow = '0;
		do_op(mkOp(CL_JUMP, SZ_WORD, 5'h00, 1'b1), 0, 0, 6, 1'b0);
	endtask : t_flow
	task automatic t_six();
		ecs_class_t cl [6] = '{CL_CTRL, CL_TRAP, CL_UNIMPL, CL_OTHER, CL_CUSTOM_COMB,
			CL_CUSTOM_MULTI};
		foreach (cl[i]) do_op(mkOp(cl[i], SZ_WORD, 5'h00, 1'b1), 0, 0, 6, 1'b0);
	endtask : t_six
	task automatic t_mem();
		dataReq = '{32'h8000_0010, 32'h80c3_5a17, 4'hf};
		do_op(mkOp(CL_STORE, SZ_WORD, 5'h00, 1'b0), 0, 2, 9, 1'b0);
		do_op(mkOp(CL_LOAD, SZ_WORD, 5'h00, 1'b1), 0, 2, 9, 1'b0);
		chk(loadResult, 32'h80c3_5a17);
		dataReq.addr = 32'h8000_0012;
		do_op(mkOp(CL_LOAD, SZ_HALF, 5'h00, 1'b1), 0, 0, 10, 1'b0);
		chk(loadResult, 32'hffff_80c3);
		dataReq.addr = 32'h8000_0013;
		do_op(mkOp(CL_LOAD, SZ_BYTE, 5'h00, 1'b1), 0, 1, 12, 1'b0);
		chk(loadResult, 32'hffff_ff80);
	endtask : t_mem
	task automatic t_shift();
		do_op(mkOp(CL_SHIFT, SZ_WORD, 5'h00, 1'b1), 0, 0, 7, 1'b0);
		do_op(mkOp(CL_SHIFT, SZ_WORD, 5'h1f, 1'b1), 0, 0, 38, 1'b0);
		do_op(mkOp(CL_SHIFT, SZ_WORD, 5'h04, 1'b1), 0, 0, 11, 1'b0);
		chk(shiftResult, 32'h0000_0a50);
	endtask : t_shift
	task automatic t_custom();
		custDelay = 3;
		do_op(mkOp(CL_CUSTOM_MULTI, SZ_WORD, 5'h00, 1'b1), 0, 0, 9, 1'b0);
		custDelay = 0;
	endtask : t_custom
	task automatic t_hold(input logic isDbg);
		logic [31:0] a;
		int          n;
		a = iAddress;
		decodedOp = mkOp(CL_ALU, SZ_WORD, 5'h00, 1'b1);
		resetRequest = !isDbg;
		debugHaltReq = isDbg;
		run_to_fetch(n);
		chk(nH > 2, 1'b1);
		chk(iAddress, isDbg ? a + INSN_STEP : RESET_VECTOR);
	endtask : t_hold

	task automatic complete_run();
		$display("checks %0d mismatches %0d", num_checks, n_mismatch);
		if (n_mismatch == 0 && num_checks > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask : complete_run

	initial begin
		int n;
		clk = 1'b0;
		reset_n = 1'b0;
		decodedOp = mkOp(CL_ALU, SZ_WORD, 5'h00, 1'b1);
		flow = '0;
		dataReq = '0;
		shiftOperand = 32'h0000_00a5;
		{irq, resetRequest, debugHaltReq, customDone} = 4'h1;
		{iWaits, dWaits, custDelay, custCnt, tick, n_mismatch, num_checks} = '0;
		repeat (5) @(negedge clk);
		reset_n = 1'b1;
		run_to_fetch(n);
		t_basic();
		t_flow();
		t_six();
		t_mem();
		t_shift();
		t_custom();
		t_hold(1'b0);
		t_hold(1'b1);
		complete_run();
	end
endmodule : test_economy_core_instruction_sequencer
